/* hw/dual_timer.sv */
// Dual four-mode timer/counter with an APB register port.
`timescale 1ns/10ps
module dual_timer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [1:0] count_pin_in,
   output logic [1:0] count_pin_out,
   output logic [1:0] count_pin_oe,
   input wire logic [1:0] gate_input_pin,
   output logic irq,
   output logic baud_tick
);
   timer_pkg::state_s st_reg;
   timer_pkg::state_s st_next;

   // ************************************************************
   // Register decode.
   // ************************************************************
   function automatic logic reg_known(input logic [7:0] a);
      case (a)
         timer_pkg::ADDR_MODE,
         timer_pkg::ADDR_CTRL,
         timer_pkg::ADDR_T0_LO,
         timer_pkg::ADDR_T0_HI,
         timer_pkg::ADDR_T1_LO,
         timer_pkg::ADDR_T1_HI,
         timer_pkg::ADDR_STATUS,
         timer_pkg::ADDR_MASK: reg_known = 1'b1;
         default: reg_known = 1'b0;
      endcase
   endfunction : reg_known

   function automatic logic [31:0] read_mux(input timer_pkg::state_s s,
                                            input logic [7:0] a);
      read_mux = 32'h0000_0000;
      case (a)
         timer_pkg::ADDR_MODE: read_mux[7:0] = s.mode_bits;
         timer_pkg::ADDR_CTRL: read_mux[3:0] = s.ctrl;
         timer_pkg::ADDR_T0_LO: read_mux[7:0] = s.t0_lo;
         timer_pkg::ADDR_T0_HI: read_mux[7:0] = s.t0_hi;
         timer_pkg::ADDR_T1_LO: read_mux[7:0] = s.t1_lo;
         timer_pkg::ADDR_T1_HI: read_mux[7:0] = s.t1_hi;
         timer_pkg::ADDR_STATUS: read_mux[1:0] = s.status;
         timer_pkg::ADDR_MASK: read_mux[1:0] = s.mask;
         default: read_mux = 32'h0000_0000;
      endcase
   endfunction : read_mux

   // ************************************************************
   // Next-state logic.
   // ************************************************************
   always_comb begin
      logic mc;
      logic [1:0] fall;
      timer_pkg::mode_e m0;
      timer_pkg::mode_e m1;
      logic tick0;
      logic tick1;
      logic ovf0;
      logic ovf1;
      logic ovf_hi;
      logic set0;
      logic set1;
      logic access;
      timer_pkg::step_s s0;
      timer_pkg::step_s s1;
      mc = 1'b0;
      fall = 2'b00;
      m0 = timer_pkg::MODE_13BIT;
      m1 = timer_pkg::MODE_13BIT;
      tick0 = 1'b0;
      tick1 = 1'b0;
      ovf0 = 1'b0;
      ovf1 = 1'b0;
      ovf_hi = 1'b0;
      set0 = 1'b0;
      set1 = 1'b0;
      access = 1'b0;
      s0 = '0;
      s1 = '0;
      st_next = st_reg;

      // Pins pass three flops; a level is accepted once the last two agree.
      st_next.sync1 = {gate_input_pin, count_pin_in};
      st_next.sync2 = st_reg.sync1;
      st_next.sync3 = st_reg.sync2;
      for (int i = 0; i < 4; i++) begin
         if (st_reg.sync2[i] == st_reg.sync3[i]) begin
            st_next.level[i] = st_reg.sync3[i];
         end
      end

      // Machine cycle enable from a divide-by-six counter.
      mc = (st_reg.div == timer_pkg::DIV_LAST);
      st_next.div = mc ? 3'h0 : st_reg.div + 3'h1;

      // The count pins are sampled once per machine cycle only, so a
      // level shorter than a machine cycle may be missed entirely.
      if (mc) begin
         fall = st_reg.prev & ~st_reg.level[1:0];
         st_next.prev = st_reg.level[1:0];
      end

      m0 = timer_pkg::mode_e'(st_reg.mode_bits[timer_pkg::MODE_M0_LSB +: 2]);
      m1 = timer_pkg::mode_e'(st_reg.mode_bits[timer_pkg::MODE_M1_LSB +: 2]);

      tick0 = st_reg.ctrl[timer_pkg::CTRL_RUN0]
         & (~st_reg.mode_bits[timer_pkg::MODE_GATE0]
            | st_reg.level[timer_pkg::PIN_GATE0])
         & (st_reg.mode_bits[timer_pkg::MODE_CT0] ? fall[0] : mc);
      tick1 = st_reg.ctrl[timer_pkg::CTRL_RUN1]
         & (m1 != timer_pkg::MODE_SPLIT)
         & (~st_reg.mode_bits[timer_pkg::MODE_GATE1]
            | st_reg.level[timer_pkg::PIN_GATE1])
         & (st_reg.mode_bits[timer_pkg::MODE_CT1] ? fall[1] : mc);

      // ************************************************************
      // Counting.
      // ************************************************************
      if (m0 == timer_pkg::MODE_SPLIT) begin
         if (tick0) begin
            {ovf0, st_next.t0_lo} = {1'b0, st_reg.t0_lo} + 9'h001;
         end
         if (st_reg.ctrl[timer_pkg::CTRL_RUN1] && mc) begin
            {ovf_hi, st_next.t0_hi} = {1'b0, st_reg.t0_hi} + 9'h001;
         end
      end else if (tick0) begin
         s0 = timer_pkg::count_step(m0, st_reg.t0_lo, st_reg.t0_hi);
         ovf0 = s0.ovf;
         st_next.t0_lo = s0.lo;
         st_next.t0_hi = s0.hi;
      end

      if (tick1) begin
         s1 = timer_pkg::count_step(m1, st_reg.t1_lo, st_reg.t1_hi);
         ovf1 = s1.ovf;
         st_next.t1_lo = s1.lo;
         st_next.t1_hi = s1.hi;
      end

      set0 = ovf0;
      // Under split mode the high byte of timer 0 owns timer 1's flag,
      // while timer 1's own overflow still drives the baud tick.
      set1 = (m0 == timer_pkg::MODE_SPLIT) ? ovf_hi : ovf1;
      st_next.baud = ovf1;

      // ************************************************************
      // Toggle outputs.
      // ************************************************************
      if (!st_reg.ctrl[timer_pkg::CTRL_TOG0]) begin
         st_next.tog[0] = 1'b1;
      end else if (ovf0) begin
         st_next.tog[0] = ~st_reg.tog[0];
      end
      if (!st_reg.ctrl[timer_pkg::CTRL_TOG1]) begin
         st_next.tog[1] = 1'b1;
      end else if (ovf1) begin
         st_next.tog[1] = ~st_reg.tog[1];
      end

      // ************************************************************
      // APB slave: one wait state, then pready for one cycle.
      // ************************************************************
      access = psel & penable;
      st_next.pready = access & ~st_reg.pready;
      // The error flag answers with pready only, so it never outlives it.
      st_next.pslverr = 1'b0;
      if (access && !st_reg.pready) begin
         st_next.prdata = pwrite ? 32'h0000_0000 : read_mux(st_reg, paddr);
         st_next.pslverr = ~reg_known(paddr);
      end

      // Software writes land after counting, so a write to a count byte
      // wins over an increment in the same cycle.
      if (access && st_reg.pready && pwrite && !st_reg.pslverr) begin
         case (paddr)
            timer_pkg::ADDR_MODE: st_next.mode_bits = pwdata[7:0];
            timer_pkg::ADDR_CTRL: st_next.ctrl = pwdata[3:0];
            timer_pkg::ADDR_T0_LO: st_next.t0_lo = pwdata[7:0];
            timer_pkg::ADDR_T0_HI: st_next.t0_hi = pwdata[7:0];
            timer_pkg::ADDR_T1_LO: st_next.t1_lo = pwdata[7:0];
            timer_pkg::ADDR_T1_HI: st_next.t1_hi = pwdata[7:0];
            timer_pkg::ADDR_STATUS: begin
               st_next.status = st_reg.status & ~pwdata[1:0];
            end
            timer_pkg::ADDR_MASK: st_next.mask = pwdata[1:0];
            default: st_next.mask = st_reg.mask;
         endcase
      end

      // An overflow in the cycle of a clear still leaves its flag set.
      st_next.status[timer_pkg::STAT_OVF0] =
         st_next.status[timer_pkg::STAT_OVF0] | set0;
      st_next.status[timer_pkg::STAT_OVF1] =
         st_next.status[timer_pkg::STAT_OVF1] | set1;
      st_next.irq = |(st_next.status & st_next.mask);
   end

   // ************************************************************
   // State register.
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign prdata = st_reg.prdata;
   assign pready = st_reg.pready;
   assign pslverr = st_reg.pslverr;
   assign count_pin_out = st_reg.tog;
   assign count_pin_oe = {st_reg.ctrl[timer_pkg::CTRL_TOG1],
                          st_reg.ctrl[timer_pkg::CTRL_TOG0]};
   assign irq = st_reg.irq;
   assign baud_tick = st_reg.baud;
endmodule : dual_timer

/* hw/timer_pkg.sv */
// Constants, types and the count step shared by the dual timer/counter.
package timer_pkg;
   // ************************************************************
   // Register map (byte addresses on the APB port).
   // ************************************************************
   localparam logic [7:0] ADDR_MODE = 8'h00;
   localparam logic [7:0] ADDR_CTRL = 8'h04;
   localparam logic [7:0] ADDR_T0_LO = 8'h08;
   localparam logic [7:0] ADDR_T0_HI = 8'h0c;
   localparam logic [7:0] ADDR_T1_LO = 8'h10;
   localparam logic [7:0] ADDR_T1_HI = 8'h14;
   localparam logic [7:0] ADDR_STATUS = 8'h18;
   localparam logic [7:0] ADDR_MASK = 8'h1c;
   // ************************************************************
   // Field positions.
   // ************************************************************
   localparam int MODE_M0_LSB = 0;
   localparam int MODE_CT0 = 2;
   localparam int MODE_GATE0 = 3;
   localparam int MODE_M1_LSB = 4;
   localparam int MODE_CT1 = 6;
   localparam int MODE_GATE1 = 7;
   localparam int CTRL_RUN0 = 0;
   localparam int CTRL_RUN1 = 1;
   localparam int CTRL_TOG0 = 2;
   localparam int CTRL_TOG1 = 3;
   localparam int STAT_OVF0 = 0;
   localparam int STAT_OVF1 = 1;
   localparam int PIN_GATE0 = 2;
   localparam int PIN_GATE1 = 3;
   localparam int LOW_BITS_13 = 5;
   // ************************************************************
   // Timing.
   // ************************************************************
   localparam int CLOCK_MHZ = 250;
   localparam int MC_CLOCKS = 6;
   localparam logic [2:0] DIV_LAST = 3'(MC_CLOCKS - 1);
   // ************************************************************
   // Types.
   // ************************************************************
   typedef enum logic [1:0] {
      MODE_13BIT = 2'b00,
      MODE_16BIT = 2'b01,
      MODE_RELOAD = 2'b10,
      MODE_SPLIT = 2'b11
   } mode_e;
   typedef struct packed {
      logic ovf;
      logic [7:0] lo;
      logic [7:0] hi;
   } step_s;
   typedef struct packed {
      logic [3:0] sync1;
      logic [3:0] sync2;
      logic [3:0] sync3;
      logic [3:0] level;
      logic [2:0] div;
      logic [1:0] prev;
      logic [7:0] mode_bits;
      logic [3:0] ctrl;
      logic [7:0] t0_lo;
      logic [7:0] t0_hi;
      logic [7:0] t1_lo;
      logic [7:0] t1_hi;
      logic [1:0] status;
      logic [1:0] mask;
      logic [1:0] tog;
      logic baud;
      logic irq;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } state_s;

   // One count step of a timer in modes 0, 1 and 2.
   function automatic step_s count_step(input mode_e m, input logic [7:0] lo,
                                        input logic [7:0] hi);
      step_s s;
      logic [13:0] sum13;
      logic [16:0] sum16;
      logic [8:0] sum8;
      s = '{ovf: 1'b0, lo: lo, hi: hi};
      sum13 = {1'b0, hi, lo[LOW_BITS_13-1:0]} + 14'h0001;
      sum16 = {1'b0, hi, lo} + 17'h00001;
      sum8 = {1'b0, lo} + 9'h001;
      case (m)
         MODE_13BIT: begin
            // The top three low-byte bits are left as they stand.
            s.ovf = sum13[13];
            s.hi = sum13[12:LOW_BITS_13];
            s.lo = {lo[7:LOW_BITS_13], sum13[LOW_BITS_13-1:0]};
         end
         MODE_16BIT: begin
            s.ovf = sum16[16];
            s.hi = sum16[15:8];
            s.lo = sum16[7:0];
         end
         MODE_RELOAD: begin
            s.ovf = sum8[8];
            s.lo = sum8[8] ? hi : sum8[7:0];
         end
         default: begin
            s.ovf = 1'b0;
         end
      endcase
      return s;
   endfunction : count_step
endpackage : timer_pkg

/* tb/dual_timer_sva.sv */
// Port-level concurrent checks for the dual timer/counter.
`timescale 1ns/10ps
module dual_timer_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [1:0] count_pin_out,
   input wire logic [1:0] count_pin_oe,
   input wire logic irq,
   input wire logic baud_tick
);
   // ******
   // Checks.
   // ******
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ready_pulse_a:
      assert property (pready |=> !pready)
      else $error("pready held past one cycle");
   ready_wait_a:
      assert property (psel && !penable |=> !pready ##1 pready)
      else $error("pready not two cycles after setup");
   err_ready_a:
      assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   zero_data_a:
      assert property (pready && (pwrite || pslverr) |-> prdata == 32'h0)
      else $error("read data not zero");
   idle_high_a:
      assert property (!count_pin_oe[0] && !$past(count_pin_oe[0]) &&
         $past(presetn) |-> count_pin_out[0])
      else $error("idle toggle pin not high");
   toggle_start_a:
      assert property ($rose(count_pin_oe[0]) |-> count_pin_out[0])
      else $error("toggle pin not high at enable");
   toggle_baud_a:
      assert property (count_pin_oe[1] && $past(count_pin_oe[1]) |->
         $changed(count_pin_out[1]) == baud_tick)
      else $error("toggle pin and overflow disagree");
   tick_gap_a:
      assert property (baud_tick |=> (!baud_tick) [*5])
      else $error("overflows closer than a machine cycle");
   cover property (baud_tick);
   cover property (pready && pslverr);
   cover property ($rose(irq));
endmodule : dual_timer_chk

bind dual_timer dual_timer_chk chk (.pclk, .presetn, .psel, .penable,
   .pwrite, .prdata, .pready, .pslverr, .count_pin_out, .count_pin_oe,
   .irq, .baud_tick);

/* tb/pin_source.sv */
// External count and gate pin source facing the timer block.
`timescale 1ns/10ps
module pin_source (
   input wire logic pclk,
   input wire logic [1:0] gate_req,
   output logic [1:0] count_lvl = 2'b11,
   output logic [1:0] gate_lvl = 2'b00
);
   always @(posedge pclk) gate_lvl <= gate_req;
   // At least eight clocks per level, so every level meets one machine-cycle sample.
   task automatic pulse(input int idx, input int n);
      repeat (n) begin
         @(posedge pclk);
         count_lvl[idx] <= 1'b0;
         repeat (8) @(posedge pclk);
         count_lvl[idx] <= 1'b1;
         repeat (8) @(posedge pclk);
      end
   endtask : pulse
endmodule : pin_source

/* tb/dual_timer_tb.sv */
// Self-checking bench for the dual timer/counter.
`timescale 1ns/10ps
module dual_timer_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, irq, baud_tick, er;
   logic [1:0] cnt_out, cnt_oe, cnt_lvl, gate_lvl, pin_lvl;
   logic [1:0] gate_req = 2'b00;
   int error_cnt = 0;
   int samples_checked = 0;
   int bauds = 0;
   // The pin carries the toggle output while enabled, else the source.
   assign pin_lvl = (cnt_oe & cnt_out) | (~cnt_oe & cnt_lvl);
   always #2 pclk = ~pclk;
   always @(posedge pclk) if (baud_tick === 1'b1) bauds <= bauds + 1;
   dual_timer uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .count_pin_in(pin_lvl),
      .count_pin_out(cnt_out), .count_pin_oe(cnt_oe),
      .gate_input_pin(gate_lvl), .irq, .baud_tick);
   pin_source src (.pclk, .gate_req, .count_lvl(cnt_lvl), .gate_lvl);
   // ******
   // Tasks.
   // ******
   task automatic final_report;
      $display("compares %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : final_report
   task automatic stall;
      error_cnt++;
      final_report();
   endtask : stall
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) stall();
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rc
   // A mode 1 slip needs far more than sixty clocks, so it runs out here.
   task automatic wait_irq;
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 60) begin
         @(posedge pclk);
         n++;
      end
      if (irq !== 1'b1) stall();
   endtask : wait_irq
   // ******
   // Sequence.
   // ******
   initial begin
      int b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      for (int a = 0; a < 8; a++) rc(8'(a * 4), 32'h0);
      chk(cnt_out, 32'h3);
      apb(1'b0, 8'h20, 32'h0);
      chk(er, 32'h1);
      chk(rd, 32'h0);
      wr(8'h1c, 32'h3);
      wr(8'h00, 32'h99);
      wr(8'h08, 32'h5a);
      wr(8'h10, 32'h5a);
      wr(8'h04, 32'h3);
      repeat (60) @(posedge pclk);
      rc(8'h08, 32'h5a);
      rc(8'h10, 32'h5a);
      gate_req <= 2'b01;
      repeat (60) @(posedge pclk);
      rc(8'h10, 32'h5a);
      apb(1'b0, 8'h08, 32'h0);
      chk(rd !== 32'h5a, 32'h1);
      wr(8'h04, 32'h0);
      wr(8'h00, 32'h0);
      wr(8'h18, 32'h3);
      wr(8'h0c, 32'hff);
      wr(8'h08, 32'hbe);
      wr(8'h04, 32'hd);
      @(posedge pclk);
      chk({cnt_oe, cnt_out}, 32'hf);
      wait_irq();
      chk({cnt_oe, cnt_out}, 32'he);
      rc(8'h0c, 32'h0);
      apb(1'b0, 8'h08, 32'h0);
      chk(rd[7:5], 32'h5);
      wr(8'h18, 32'h1);
      @(posedge pclk);
      chk(irq, 32'h0);
      wr(8'h04, 32'h0);
      wr(8'h18, 32'h3);
      wr(8'h1c, 32'h1);
      wr(8'h00, 32'h33);
      wr(8'h0c, 32'hfe);
      wr(8'h08, 32'hfd);
      wr(8'h04, 32'h2);
      repeat (24) @(posedge pclk);
      rc(8'h18, 32'h2);
      chk(irq, 32'h0);
      rc(8'h10, 32'h5a);
      rc(8'h08, 32'hfd);
      wr(8'h04, 32'h3);
      wait_irq();
      wr(8'h04, 32'h0);
      wr(8'h00, 32'h63);
      wr(8'h14, 32'hfd);
      wr(8'h10, 32'hfd);
      b0 = bauds;
      wr(8'h04, 32'h2);
      src.pulse(1, 4);
      repeat (12) @(posedge pclk);
      rc(8'h10, 32'hfe);
      rc(8'h14, 32'hfd);
      chk(32'(bauds - b0), 32'h1);
      final_report();
   end
endmodule : dual_timer_tb
